// ### hdl/jsdr_params.svh
// Constants for the scan data register block
`ifndef JSDR_PARAMS_SVH
`define JSDR_PARAMS_SVH
`define JSDR_IR_W          4
`define JSDR_IR_EXTEST     4'h0
`define JSDR_IR_INTEST     4'h1
`define JSDR_IR_SAMPLE     4'h2
`define JSDR_IR_ABORT      4'h8
`define JSDR_IR_DP_ACCESS  4'ha
`define JSDR_IR_AP_ACCESS  4'hb
`define JSDR_IR_IDENT      4'he
`define JSDR_IR_BYPASS     4'hf
`define JSDR_IR_CAPTURE    4'h1
`define JSDR_ID_W          32
`define JSDR_DAU_W         35
`define JSDR_NPADS         8
`define JSDR_CELLS         3
`define JSDR_BS_W          (`JSDR_CELLS * `JSDR_NPADS)
`define JSDR_CELL_IN       0
`define JSDR_CELL_OUT      1
`define JSDR_CELL_OE       2
`define JSDR_ABT_REQ_BIT   3
`define JSDR_ABT_CLR_LO    4
`define JSDR_ABT_CLR_HI    7
`define JSDR_DAU_SEL_ABORT 2'h0
`define JSDR_DAU_SEL_DP    2'h1
`define JSDR_DAU_SEL_AP    2'h2
`endif

// ### hdl/jsdr_pkg.sv
// Types and instruction decode for the scan data register block
`default_nettype none
`include "jsdr_params.svh"
package jsdr_pkg;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAPTURE_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPDATE_DR, TAP_SEL_IR, TAP_CAPTURE_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPDATE_IR
    } jsdr_tap_state_t;

    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_IDENT, SEL_BSCAN, SEL_ABORT, SEL_DP, SEL_AP
    } jsdr_dr_sel_t;

    function automatic jsdr_dr_sel_t jsdr_decode_ir(input logic [`JSDR_IR_W-1:0] ir);
        case (ir)
            `JSDR_IR_EXTEST, `JSDR_IR_INTEST, `JSDR_IR_SAMPLE: jsdr_decode_ir = SEL_BSCAN;
            `JSDR_IR_ABORT:     jsdr_decode_ir = SEL_ABORT;
            `JSDR_IR_DP_ACCESS: jsdr_decode_ir = SEL_DP;
            `JSDR_IR_AP_ACCESS: jsdr_decode_ir = SEL_AP;
            `JSDR_IR_IDENT:     jsdr_decode_ir = SEL_IDENT;
            default:            jsdr_decode_ir = SEL_BYPASS;
        endcase
    endfunction : jsdr_decode_ir
endpackage : jsdr_pkg
`default_nettype wire

// ### hdl/jsdr_if.sv
// Internal link between the top, state machine and boundary chain
`timescale 1ns/1ns
`default_nettype none
`include "jsdr_params.svh"
interface jsdr_if;
    logic                         tck_rise;
    logic                         tck_fall;
    logic                         tms;
    logic                         tdi;
    logic                         trst_low;
    logic [`JSDR_IR_W-1:0]        ir;
    jsdr_pkg::jsdr_dr_sel_t       sel;
    jsdr_pkg::jsdr_tap_state_t    state;
    logic                         bs_so;

    modport tap (input tck_rise, input tms, input trst_low, output state);
    modport bsc (input tck_rise, input tdi, input ir, input sel, input state, output bs_so);
    modport top (output tck_rise, output tck_fall, output tms, output tdi, output trst_low,
                 output ir, output sel, input state, input bs_so);
endinterface : jsdr_if
`default_nettype wire

// ### hdl/jsdr_tap_fsm.sv
// Test access port sixteen-state controller
`timescale 1ns/1ns
`default_nettype none
module jsdr_tap_fsm (
    input  wire logic clk_i,     // System clock
    input  wire logic rst_b_i,   // Power-on reset, active low
    jsdr_if.tap       ifc        // Sampled test pins and state
);
    typedef jsdr_pkg::jsdr_tap_state_t st_t;

    function automatic st_t next_state(input st_t s, input logic m);
        case (s)
            jsdr_pkg::TAP_RESET:      next_state = m ? jsdr_pkg::TAP_RESET : jsdr_pkg::TAP_IDLE;
            jsdr_pkg::TAP_IDLE:       next_state = m ? jsdr_pkg::TAP_SEL_DR : jsdr_pkg::TAP_IDLE;
            jsdr_pkg::TAP_SEL_DR:     next_state = m ? jsdr_pkg::TAP_SEL_IR : jsdr_pkg::TAP_CAPTURE_DR;
            jsdr_pkg::TAP_CAPTURE_DR: next_state = m ? jsdr_pkg::TAP_EXIT1_DR : jsdr_pkg::TAP_SHIFT_DR;
            jsdr_pkg::TAP_SHIFT_DR:   next_state = m ? jsdr_pkg::TAP_EXIT1_DR : jsdr_pkg::TAP_SHIFT_DR;
            jsdr_pkg::TAP_EXIT1_DR:   next_state = m ? jsdr_pkg::TAP_UPDATE_DR : jsdr_pkg::TAP_PAUSE_DR;
            jsdr_pkg::TAP_PAUSE_DR:   next_state = m ? jsdr_pkg::TAP_EXIT2_DR : jsdr_pkg::TAP_PAUSE_DR;
            jsdr_pkg::TAP_EXIT2_DR:   next_state = m ? jsdr_pkg::TAP_UPDATE_DR : jsdr_pkg::TAP_SHIFT_DR;
            jsdr_pkg::TAP_UPDATE_DR:  next_state = m ? jsdr_pkg::TAP_SEL_DR : jsdr_pkg::TAP_IDLE;
            jsdr_pkg::TAP_SEL_IR:     next_state = m ? jsdr_pkg::TAP_RESET : jsdr_pkg::TAP_CAPTURE_IR;
            jsdr_pkg::TAP_CAPTURE_IR: next_state = m ? jsdr_pkg::TAP_EXIT1_IR : jsdr_pkg::TAP_SHIFT_IR;
            jsdr_pkg::TAP_SHIFT_IR:   next_state = m ? jsdr_pkg::TAP_EXIT1_IR : jsdr_pkg::TAP_SHIFT_IR;
            jsdr_pkg::TAP_EXIT1_IR:   next_state = m ? jsdr_pkg::TAP_UPDATE_IR : jsdr_pkg::TAP_PAUSE_IR;
            jsdr_pkg::TAP_PAUSE_IR:   next_state = m ? jsdr_pkg::TAP_EXIT2_IR : jsdr_pkg::TAP_PAUSE_IR;
            jsdr_pkg::TAP_EXIT2_IR:   next_state = m ? jsdr_pkg::TAP_UPDATE_IR : jsdr_pkg::TAP_SHIFT_IR;
            jsdr_pkg::TAP_UPDATE_IR:  next_state = m ? jsdr_pkg::TAP_SEL_DR : jsdr_pkg::TAP_IDLE;
            default:                  next_state = jsdr_pkg::TAP_RESET;
        endcase
    endfunction : next_state

    st_t state_r;
    st_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (ifc.trst_low) begin
            state_nxt = jsdr_pkg::TAP_RESET;
        end else if (ifc.tck_rise) begin
            state_nxt = next_state(state_r, ifc.tms);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r <= jsdr_pkg::TAP_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ifc.state = state_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_trst_forces_reset: assert property (ifc.trst_low |=> state_r == jsdr_pkg::TAP_RESET)
        else $error("test reset did not force reset state");
    a_tms_holds_reset: assert property (state_r == jsdr_pkg::TAP_RESET && ifc.tck_rise && ifc.tms
        |=> state_r == jsdr_pkg::TAP_RESET)
        else $error("reset state left with tms high");
    a_state_only_on_edge: assert property (!ifc.tck_rise && !ifc.trst_low |=> $stable(state_r))
        else $error("state moved without a test clock edge");
endmodule : jsdr_tap_fsm
`default_nettype wire

// ### hdl/jsdr_bscan.sv
// Boundary scan chain with parallel hold cells and pad muxing
`timescale 1ns/1ns
`default_nettype none
`include "jsdr_params.svh"
module jsdr_bscan (
    input  wire logic                   clk_i,       // System clock
    input  wire logic                   rst_b_i,     // Power-on reset, active low
    jsdr_if.bsc                         ifc,         // Test sequencing
    input  wire logic [`JSDR_NPADS-1:0] pad_in_i,    // Pad input levels (async)
    input  wire logic [`JSDR_NPADS-1:0] core_out_i,  // Core output values
    input  wire logic [`JSDR_NPADS-1:0] core_oe_i,   // Core output enables
    output logic      [`JSDR_NPADS-1:0] pad_out_o,   // Value toward pads
    output logic      [`JSDR_NPADS-1:0] pad_oe_o,    // Enable toward pads
    output logic      [`JSDR_NPADS-1:0] core_in_o    // Input value toward core
);
    typedef struct packed {
        logic [`JSDR_NPADS-1:0] pad_s1;
        logic [`JSDR_NPADS-1:0] pad_s2;
        logic [`JSDR_BS_W-1:0]  sr;
        logic [`JSDR_BS_W-1:0]  hold;
        logic [`JSDR_NPADS-1:0] pad_out;
        logic [`JSDR_NPADS-1:0] pad_oe;
        logic [`JSDR_NPADS-1:0] core_in;
    } jsdr_bsc_st_t;

    jsdr_bsc_st_t r;
    jsdr_bsc_st_t n;
    logic [`JSDR_BS_W-1:0]  cap;
    logic [`JSDR_NPADS-1:0] h_in, h_out, h_oe;
    logic                   bs_sel;

    // Pad nearest the test pins first: input, output, enable
    for (genvar i = 0; i < `JSDR_NPADS; i++) begin : g_cell
        assign cap[`JSDR_CELLS*i+`JSDR_CELL_IN]  = r.pad_s2[i];
        assign cap[`JSDR_CELLS*i+`JSDR_CELL_OUT] = core_out_i[i];
        assign cap[`JSDR_CELLS*i+`JSDR_CELL_OE]  = core_oe_i[i];
        assign h_in[i]  = r.hold[`JSDR_CELLS*i+`JSDR_CELL_IN];
        assign h_out[i] = r.hold[`JSDR_CELLS*i+`JSDR_CELL_OUT];
        assign h_oe[i]  = r.hold[`JSDR_CELLS*i+`JSDR_CELL_OE];
    end

    assign bs_sel = (ifc.sel == jsdr_pkg::SEL_BSCAN);

    always_comb begin
        n = r;
        n.pad_s1 = pad_in_i;
        n.pad_s2 = r.pad_s1;
        if (ifc.tck_rise && bs_sel) begin
            case (ifc.state)
                jsdr_pkg::TAP_CAPTURE_DR: n.sr = cap;
                jsdr_pkg::TAP_SHIFT_DR:   n.sr = {ifc.tdi, r.sr[`JSDR_BS_W-1:1]};
                jsdr_pkg::TAP_UPDATE_DR:  n.hold = r.sr;
                default:                  n.sr = r.sr;
            endcase
        end
        // Registered muxes cost a cycle but keep pads glitch free
        n.pad_out = (ifc.ir == `JSDR_IR_EXTEST) ? h_out : core_out_i;
        n.pad_oe  = (ifc.ir == `JSDR_IR_EXTEST) ? h_oe  : core_oe_i;
        n.core_in = (ifc.ir == `JSDR_IR_INTEST) ? h_in  : r.pad_s2;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign ifc.bs_so = r.sr[0];
    assign pad_out_o = r.pad_out;
    assign pad_oe_o  = r.pad_oe;
    assign core_in_o = r.core_in;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_capture_pads: assert property (ifc.tck_rise && bs_sel && ifc.state == jsdr_pkg::TAP_CAPTURE_DR
        |=> r.sr == $past(cap))
        else $error("boundary capture mismatch");
    a_update_hold: assert property (ifc.tck_rise && bs_sel && ifc.state == jsdr_pkg::TAP_UPDATE_DR
        |=> r.hold == $past(r.sr))
        else $error("boundary hold not updated");
    a_extest_drives: assert property (ifc.ir == `JSDR_IR_EXTEST
        |=> pad_out_o == $past(h_out) && pad_oe_o == $past(h_oe))
        else $error("pads not driven from hold cells");
endmodule : jsdr_bscan
`default_nettype wire

// ### hdl/jsdr_top.sv
// Scan data registers behind the test access port
`timescale 1ns/1ns
`default_nettype none
`include "jsdr_params.svh"
module jsdr_top #(
    parameter logic [`JSDR_ID_W-1:0] ID_VALUE = 32'h1234_5671  // Arbitrary identification value
) (
    input  wire logic                    clk_i,        // System clock, 100 MHz
    input  wire logic                    rst_b_i,      // Power-on reset, active low
    input  wire logic                    tck_i,        // Test clock pin
    input  wire logic                    tms_i,        // Test mode select pin
    input  wire logic                    tdi_i,        // Test data in pin
    input  wire logic                    trst_b_i,     // Test reset pin, active low
    output logic                         tdo_o,        // Test data out value
    output logic                         tdo_oe_b_o,   // Test data out enable, active low
    input  wire logic [`JSDR_NPADS-1:0]  pad_in_i,     // Pad input levels
    input  wire logic [`JSDR_NPADS-1:0]  core_out_i,   // Core output values
    input  wire logic [`JSDR_NPADS-1:0]  core_oe_i,    // Core output enables
    output logic      [`JSDR_NPADS-1:0]  pad_out_o,    // Values toward pads
    output logic      [`JSDR_NPADS-1:0]  pad_oe_o,     // Enables toward pads
    output logic      [`JSDR_NPADS-1:0]  core_in_o,    // Inputs toward core
    input  wire logic [`JSDR_DAU_W-1:0]  dau_rdata_i,  // Debug unit read result
    output logic                         dau_wr_o,     // Debug unit update strobe
    output logic      [1:0]              dau_sel_o,    // Chain that updated
    output logic      [`JSDR_DAU_W-1:0]  dau_data_o,   // Updated chain word
    output logic                         dau_abort_o,  // Abort request pulse
    output logic                         dau_clr_o     // Sticky flag clear pulse
);
    typedef struct packed {
        logic [2:0]             tck_sy;
        logic [1:0]             tms_sy;
        logic [1:0]             tdi_sy;
        logic [1:0]             trst_sy;
        logic [`JSDR_IR_W-1:0]  ir_sr;
        logic [`JSDR_IR_W-1:0]  ir;
        logic [`JSDR_ID_W-1:0]  id_sr;
        logic                   byp_sr;
        logic [`JSDR_DAU_W-1:0] dau_sr;
        logic                   tdo;
        logic                   tdo_oe_b;
        logic                   dau_wr;
        logic [1:0]             dau_sel;
        logic [`JSDR_DAU_W-1:0] dau_data;
        logic                   dau_abort;
        logic                   dau_clr;
    } jsdr_top_st_t;

    localparam logic [`JSDR_ID_W-1:0] ID_WORD = {ID_VALUE[`JSDR_ID_W-1:1], 1'b1};

    jsdr_top_st_t r;
    jsdr_top_st_t n;
    jsdr_if       ifc ();
    logic         dr_so;
    logic         dau_chain;

    jsdr_tap_fsm u_fsm (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ifc     (ifc.tap)
    );

    jsdr_bscan u_bsc (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .ifc        (ifc.bsc),
        .pad_in_i   (pad_in_i),
        .core_out_i (core_out_i),
        .core_oe_i  (core_oe_i),
        .pad_out_o  (pad_out_o),
        .pad_oe_o   (pad_oe_o),
        .core_in_o  (core_in_o)
    );

    // Edges found from the second sync stage against the third
    assign ifc.tck_rise = r.tck_sy[1] & ~r.tck_sy[2];
    assign ifc.tck_fall = ~r.tck_sy[1] & r.tck_sy[2];
    assign ifc.tms      = r.tms_sy[1];
    assign ifc.tdi      = r.tdi_sy[1];
    assign ifc.trst_low = ~r.trst_sy[1];
    assign ifc.ir       = r.ir;
    assign ifc.sel      = jsdr_pkg::jsdr_decode_ir(r.ir);

    assign dau_chain = (ifc.sel == jsdr_pkg::SEL_ABORT) || (ifc.sel == jsdr_pkg::SEL_DP)
                    || (ifc.sel == jsdr_pkg::SEL_AP);

    // Serial path chosen by the current instruction
    always_comb begin
        case (ifc.sel)
            jsdr_pkg::SEL_IDENT: dr_so = r.id_sr[0];
            jsdr_pkg::SEL_BSCAN: dr_so = ifc.bs_so;
            jsdr_pkg::SEL_ABORT: dr_so = r.dau_sr[0];
            jsdr_pkg::SEL_DP:    dr_so = r.dau_sr[0];
            jsdr_pkg::SEL_AP:    dr_so = r.dau_sr[0];
            default:             dr_so = r.byp_sr;
        endcase
    end

    always_comb begin
        n = r;
        n.tck_sy  = {r.tck_sy[1:0], tck_i};
        n.tms_sy  = {r.tms_sy[0], tms_i};
        n.tdi_sy  = {r.tdi_sy[0], tdi_i};
        n.trst_sy = {r.trst_sy[0], trst_b_i};
        n.dau_wr    = 1'b0;
        n.dau_abort = 1'b0;
        n.dau_clr   = 1'b0;
        if (ifc.state == jsdr_pkg::TAP_RESET) begin
            n.ir = `JSDR_IR_IDENT;
        end else if (ifc.tck_rise) begin
            case (ifc.state)
                jsdr_pkg::TAP_CAPTURE_IR: n.ir_sr = `JSDR_IR_CAPTURE;
                jsdr_pkg::TAP_SHIFT_IR:   n.ir_sr = {ifc.tdi, r.ir_sr[`JSDR_IR_W-1:1]};
                jsdr_pkg::TAP_UPDATE_IR:  n.ir = r.ir_sr;
                jsdr_pkg::TAP_CAPTURE_DR: begin
                    case (ifc.sel)
                        jsdr_pkg::SEL_IDENT:  n.id_sr = ID_WORD;
                        jsdr_pkg::SEL_ABORT:  n.dau_sr = '0;
                        jsdr_pkg::SEL_DP:     n.dau_sr = dau_rdata_i;
                        jsdr_pkg::SEL_AP:     n.dau_sr = dau_rdata_i;
                        jsdr_pkg::SEL_BSCAN:  n.byp_sr = r.byp_sr;
                        default:              n.byp_sr = 1'b0;
                    endcase
                end
                jsdr_pkg::TAP_SHIFT_DR: begin
                    case (ifc.sel)
                        jsdr_pkg::SEL_IDENT: n.id_sr = {ifc.tdi, r.id_sr[`JSDR_ID_W-1:1]};
                        jsdr_pkg::SEL_ABORT,
                        jsdr_pkg::SEL_DP,
                        jsdr_pkg::SEL_AP:    n.dau_sr = {ifc.tdi, r.dau_sr[`JSDR_DAU_W-1:1]};
                        jsdr_pkg::SEL_BSCAN: n.byp_sr = r.byp_sr;
                        default:             n.byp_sr = ifc.tdi;
                    endcase
                end
                jsdr_pkg::TAP_UPDATE_DR: begin
                    if (dau_chain) begin
                        n.dau_wr   = 1'b1;
                        n.dau_data = r.dau_sr;
                    end
                    case (ifc.sel)
                        jsdr_pkg::SEL_ABORT: begin
                            n.dau_sel   = `JSDR_DAU_SEL_ABORT;
                            n.dau_abort = r.dau_sr[`JSDR_ABT_REQ_BIT];
                            n.dau_clr   = |r.dau_sr[`JSDR_ABT_CLR_HI:`JSDR_ABT_CLR_LO];
                        end
                        jsdr_pkg::SEL_DP: n.dau_sel = `JSDR_DAU_SEL_DP;
                        jsdr_pkg::SEL_AP: n.dau_sel = `JSDR_DAU_SEL_AP;
                        default:          n.dau_sel = r.dau_sel;
                    endcase
                end
                default: n.ir_sr = r.ir_sr;
            endcase
        end
        // Output moves on the falling edge so the tester samples a settled bit
        if (ifc.tck_fall) begin
            case (ifc.state)
                jsdr_pkg::TAP_SHIFT_IR: begin
                    n.tdo      = r.ir_sr[0];
                    n.tdo_oe_b = 1'b0;
                end
                jsdr_pkg::TAP_SHIFT_DR: begin
                    n.tdo      = dr_so;
                    n.tdo_oe_b = 1'b0;
                end
                default: n.tdo_oe_b = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            r          <= '0;
            r.ir       <= `JSDR_IR_IDENT;
            r.trst_sy  <= 2'h3;
            r.tdo_oe_b <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign tdo_o       = r.tdo;
    assign tdo_oe_b_o  = r.tdo_oe_b;
    assign dau_wr_o    = r.dau_wr;
    assign dau_sel_o   = r.dau_sel;
    assign dau_data_o  = r.dau_data;
    assign dau_abort_o = r.dau_abort;
    assign dau_clr_o   = r.dau_clr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_ident_on_reset: assert property (ifc.state == jsdr_pkg::TAP_RESET
        |=> r.ir == `JSDR_IR_IDENT)
        else $error("identification not selected in reset state");
    a_tdo_released: assert property (ifc.tck_fall && ifc.state != jsdr_pkg::TAP_SHIFT_DR
        && ifc.state != jsdr_pkg::TAP_SHIFT_IR |=> tdo_oe_b_o)
        else $error("data out driven outside shift states");
    a_tdo_bscan_path: assert property (ifc.tck_fall && ifc.state == jsdr_pkg::TAP_SHIFT_DR
        && ifc.sel == jsdr_pkg::SEL_BSCAN |=> !tdo_oe_b_o && tdo_o == $past(ifc.bs_so))
        else $error("boundary chain not on data out");
    a_ident_lsb: assert property (ifc.tck_rise && ifc.state == jsdr_pkg::TAP_CAPTURE_DR
        && ifc.sel == jsdr_pkg::SEL_IDENT |=> r.id_sr == ID_WORD && r.id_sr[0])
        else $error("identification capture wrong");
    a_bypass_zero: assert property (ifc.tck_rise && ifc.state == jsdr_pkg::TAP_CAPTURE_DR
        && ifc.sel == jsdr_pkg::SEL_BYPASS |=> !r.byp_sr)
        else $error("bypass did not capture zero");
    a_dp_strobe: assert property (ifc.tck_rise && ifc.state == jsdr_pkg::TAP_UPDATE_DR
        && ifc.sel == jsdr_pkg::SEL_DP |=> dau_wr_o && dau_sel_o == `JSDR_DAU_SEL_DP
        && dau_data_o == $past(r.dau_sr) ##1 !dau_wr_o)
        else $error("debug port update strobe wrong");
    a_unlisted_bypass: assert property (r.ir == 4'h5 |-> ifc.sel == jsdr_pkg::SEL_BYPASS)
        else $error("unlisted code not treated as bypass");

    c_ir_update: cover property (ifc.tck_rise && ifc.state == jsdr_pkg::TAP_UPDATE_IR);
    c_dau_write: cover property (dau_wr_o && dau_sel_o == `JSDR_DAU_SEL_AP);
    c_abort_req: cover property (dau_abort_o);
    c_extest_on: cover property (r.ir == `JSDR_IR_EXTEST && !tdo_oe_b_o);
endmodule : jsdr_top
`default_nettype wire

// ### sim/jsdr_probe.sv
// Probe model that drives the test clock, mode select and data in pins
`timescale 1ns/1ns
`default_nettype none
module jsdr_probe (
    input  wire logic clk_i,      // Clock
    input  wire logic tdo_i,      // Data out
    input  wire logic tdo_oe_b_i, // Enable, low
    output logic      tck_o,      // Test clock
    output logic      tms_o,      // Mode select
    output logic      tdi_o       // Data in
);
    logic last_r;
    logic tdo_w;
    // Released pin flips, so a stale bit cannot pass
    assign tdo_w = tdo_oe_b_i ? ~last_r : tdo_i;
    always @(posedge clk_i) if (!tdo_oe_b_i) last_r <= tdo_i;
    initial tck_o = 1'b0;
    initial tms_o = 1'b1;
    initial tdi_o = 1'b0;
    task automatic step(input logic ms, input logic di, output logic dout);
        tms_o = ms;
        tdi_o = di;
        @(negedge clk_i);
        tck_o = 1'b1;
        repeat (8) @(negedge clk_i);
        tck_o = 1'b0;
        repeat (7) @(negedge clk_i);
        dout = tdo_w;
    endtask : step
endmodule : jsdr_probe
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the scan data register block
`timescale 1ns/1ns
`default_nettype none
`include "jsdr_params.svh"
module testbench;
    localparam logic [31:0] ID = 32'h0bad_cafe; // Arbitrary value
    logic clk_i = 1'b0, rst_b_i = 1'b0, trst_b_i = 1'b1, t;
    logic tck, tms, tdi, tdo, oe_b, wr, abt, clr;
    logic [7:0] pin = 8'ha5, cout = 8'h3c, coe = 8'hf0, pout, poe, cin;
    logic [1:0] sel;
    logic [2:0] saw = 3'h0;
    logic       clr_saw = 1'b0;
    logic [34:0] rd = 35'h0, dd, r, e;
    int n_errors = 0, num_checks = 0, cyc = 0;
    jsdr_top #(.ID_VALUE(ID)) u_jsdr_top (.clk_i, .rst_b_i, .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .trst_b_i, .tdo_o(tdo), .tdo_oe_b_o(oe_b), .pad_in_i(pin),
        .core_out_i(cout), .core_oe_i(coe), .pad_out_o(pout), .pad_oe_o(poe),
        .core_in_o(cin), .dau_rdata_i(rd), .dau_wr_o(wr), .dau_sel_o(sel),
        .dau_data_o(dd), .dau_abort_o(abt), .dau_clr_o(clr));
    jsdr_probe probe (.clk_i, .tdo_i(tdo), .tdo_oe_b_i(oe_b), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        saw <= clr_saw ? 3'h0 : (saw | {wr, clr, abt});
        if (cyc == 30000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [34:0] ex, input logic [34:0] g);
        num_checks++;
        if (g !== ex) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, ex, g);
        end
    endtask : chk
    // Walk from Idle through one scan and back to Idle
    task automatic scan(input logic ir, input int n, input logic [34:0] din);
        r = '0;
        probe.step(1'b1, 1'b0, t);
        if (ir) probe.step(1'b1, 1'b0, t);
        probe.step(1'b0, 1'b0, t);
        probe.step(1'b0, 1'b0, t);
        r[0] = t;
        for (int k = 0; k < n; k++) begin
            probe.step(k == n - 1, din[k], t);
            if (k < n - 1) r[k + 1] = t;
        end
        chk("oe_b", 35'h1, oe_b);
        probe.step(1'b1, 1'b0, t);
        probe.step(1'b0, 1'b0, t);
    endtask : scan
    task automatic ir_load(input logic [3:0] c);
        scan(1'b1, 4, c);
        chk("ir_cap", 35'h1, r);
    endtask : ir_load
    task automatic t_ident();
        scan(1'b0, 32, 35'h0);
        chk("ident", {ID[31:1], 1'b1}, r);
    endtask : t_ident
    task automatic t_bypass();
        logic [3:0] codes [4] = '{4'hf, 4'h5, 4'hc, 4'h7};
        foreach (codes[i]) begin
            ir_load(codes[i]);
            scan(1'b0, 2, 35'h1);
            chk("bypass", 35'h2, r);
        end
    endtask : t_bypass
    task automatic t_bscan();
        e = '0;
        for (int p = 0; p < 8; p++) e[3*p +: 3] = {coe[p], cout[p], pin[p]};
        ir_load(4'h2);
        scan(1'b0, 24, 35'h5ac396);
        chk("capture", e, r);
        e = 35'h5ac396;
        ir_load(4'h0);
        for (int p = 0; p < 8; p++) chk("pad", {e[3*p+2], e[3*p+1]}, {poe[p], pout[p]});
        ir_load(4'h1);
        for (int p = 0; p < 8; p++) chk("core_in", e[3*p], cin[p]);
    endtask : t_bscan
    task automatic t_dau(input logic [3:0] c, input logic [1:0] s, input logic [34:0] d);
        rd = 35'h4_1234_5678;
        clr_saw = 1'b1;
        ir_load(c);
        clr_saw = 1'b0;
        scan(1'b0, 35, d);
        chk("dau_cap", (s == 2'h0) ? 35'h0 : rd, r);
        chk("dau_sel", s, sel);
        chk("dau_data", d, dd);
        chk("strobes", (s == 2'h0) ? 3'h7 : 3'h4, saw);
    endtask : t_dau
    initial begin
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_i);
        probe.step(1'b0, 1'b0, t);
        t_ident();
        t_bypass();
        t_bscan();
        t_dau(4'h8, 2'h0, 35'h18);
        t_dau(4'ha, 2'h1, 35'h2_aaaa_5555);
        t_dau(4'hb, 2'h2, 35'h5_5aa5_0ff0);
        repeat (5) probe.step(1'b1, 1'b0, t);
        probe.step(1'b0, 1'b0, t);
        t_ident();
        ir_load(4'hf);
        trst_b_i = 1'b0;
        repeat (5) @(negedge clk_i);
        trst_b_i = 1'b1;
        repeat (3) @(negedge clk_i);
        probe.step(1'b0, 1'b0, t);
        t_ident();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
